// ### testbench.sv
// Self-checking bench for the write lock and kill control
`timescale 1ns/1ps
`default_nettype none
`include "wlk_regs.vh"
module testbench;
  localparam logic [3:0] ACK = `WLK_RSP_ACK;
  localparam logic [3:0] NAK = `WLK_RSP_NEGATIVE_ACK_CODE_ZERO;
  localparam logic [3:0] OFF = 4'hF;
  logic        mclk, sys_rst, cmd_valid, cmd_ready, cmd_write, rsp_valid, killed, kill_pend;
  logic [5:0]  cmd_block;
  logic [3:0]  rsp_code;
  logic [31:0] cmd_data, rsp_data;
  int          miscompares, comparisons;

  wlk_write_lock_ctrl i_wlk_write_lock_ctrl (
    .MCLK(mclk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_WRITE(cmd_write), .CMD_BLOCK(cmd_block), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid),
    .RSP_CODE(rsp_code), .RSP_DATA(rsp_data), .KILLED(killed), .KILL_PENDING(kill_pend));
  wlk_reader i_wlk_reader (
    .mclk(mclk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
    .rsp_data(rsp_data), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_block(cmd_block),
    .cmd_data(cmd_data));

  // Clock at 20 MHz
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic fail(input string m);
    miscompares++;
    $display("[FAIL] %0t ns: %s", $time, m);
  endtask
  task automatic chk_code(input logic [3:0] g, input logic [3:0] e);
    comparisons++;
    if (g !== e) fail("response code");
  endtask
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) fail("read data");
  endtask
  task automatic chk_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) fail("status bit");
  endtask

  // One access: d is write data or expected read data; OFF expects silence
  task automatic acc(input logic w, input logic [5:0] b, input logic [31:0] d,
                     input logic [3:0] e);
    logic        g;
    logic [3:0]  c;
    logic [31:0] x;
    i_wlk_reader.xfer(w, b, w ? d : 32'h00000000, w ? 0 : 2, g, c, x);
    chk_bit(g, e !== OFF);
    if (g === 1'b1) chk_code(c, e);
    if (g === 1'b1 && !w) chk_data(x, d);
  endtask

  // Power cycle: reset for 3 clocks, then wait two edges before returning
  task automatic power_up;
    @(posedge mclk);
    #1;
    sys_rst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic wrap_up;
    $display("Counts: %0d miscompares, %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #100000;
    fail("watchdog");
    wrap_up;
  end

  // Main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    power_up;
    acc(1'b1, 6'h00, 32'hA5A5A5A5, NAK);
    acc(1'b1, 6'h04, 32'hCAFE0004, ACK);
    acc(1'b1, 6'h02, 32'h0010FFFF, ACK);
    acc(1'b0, 6'h02, 32'h00100000, ACK);
    acc(1'b1, 6'h04, 32'h11111111, NAK);
    acc(1'b0, 6'h04, 32'hCAFE0004, ACK);
    acc(1'b1, 6'h02, 32'h00000000, ACK);
    acc(1'b1, 6'h02, 32'h00020000, ACK);
    acc(1'b1, 6'h02, 32'h00200000, ACK);
    acc(1'b1, 6'h02, 32'h04010000, ACK);
    acc(1'b1, 6'h02, 32'h00040000, ACK);
    acc(1'b1, 6'h02, 32'h08080000, ACK);
    acc(1'b0, 6'h02, 32'h04170000, ACK);
    acc(1'b1, 6'h05, 32'h00000005, ACK);
    acc(1'b1, 6'h03, 32'h00000003, ACK);
    acc(1'b1, 6'h0A, 32'h0000000A, NAK);
    acc(1'b1, 6'h0B, 32'h0000000B, ACK);
    acc(1'b1, 6'h2C, 32'h0083C001, ACK);
    acc(1'b1, 6'h10, 32'h00000010, NAK);
    acc(1'b1, 6'h11, 32'h00000011, NAK);
    acc(1'b1, 6'h12, 32'h00000012, ACK);
    acc(1'b1, 6'h3F, 32'h0000003F, NAK);
    acc(1'b1, 6'h2D, 32'h0000002D, ACK);
    acc(1'b1, 6'h32, 32'h00000032, ACK);
    acc(1'b1, 6'h2F, 32'h12345678, ACK);
    acc(1'b0, 6'h2F, 32'h00000000, ACK);
    acc(1'b1, 6'h30, 32'h12345677, NAK);
    chk_bit(kill_pend, 1'b0);
    acc(1'b1, 6'h30, 32'h12345678, ACK);
    acc(1'b1, 6'h06, 32'h00000006, ACK);
    chk_bit(kill_pend, 1'b1);
    chk_bit(killed, 1'b0);
    acc(1'b1, 6'h2C, 32'h1C000000, ACK);
    acc(1'b0, 6'h2C, 32'h1C83C001, ACK);
    acc(1'b1, 6'h2E, 32'h0000002E, NAK);
    acc(1'b1, 6'h2F, 32'h00000000, NAK);
    acc(1'b1, 6'h30, 32'h12345678, NAK);
    power_up;
    chk_bit(killed, 1'b1);
    acc(1'b1, 6'h04, 32'h00000044, OFF);
    power_up;
    chk_bit(killed, 1'b1);
    acc(1'b1, 6'h2F, 32'h00000000, OFF);
    wrap_up;
  end
endmodule
`default_nettype wire

// ### wlk_lock_map.v
// Block to lock bit decoder: tells whether a block may no longer be written
`timescale 1ns/1ps
`default_nettype none
`include "wlk_regs.vh"
module wlk_lock_map #(
  parameter ADDR_W = 6
) (
  input  wire [ADDR_W-1:0] blk,
  input  wire [15:0]       static_bits,
  input  wire [23:0]       dyn_bits,
  input  wire [4:0]        sys_bits,
  output reg               locked
);
  reg [5:0] sys_idx;
  reg [5:0] pair_off;
  reg [4:0] pair_idx;

  // -----------------------------------------
  // Lock lookup
  // -----------------------------------------
  // Identity blocks never accept writes; block 2 is never locked itself
  always @* begin
    sys_idx  = blk - `WLK_BLK_LOCKS;
    pair_off = blk - `WLK_BLK_DYN_BASE;
    pair_idx = pair_off[5:1];
    locked   = 1'b0;
    if (blk <= `WLK_BLK_UID_LAST) begin
      locked = 1'b1;
    end else if (blk >= `WLK_BLK_CC && blk <= `WLK_BLK_STAT_LAST) begin
      locked = static_bits[blk[3:0]];
    end else if (blk >= `WLK_BLK_LOCKS && blk <= `WLK_BLK_KILL) begin
      locked = sys_bits[sys_idx[2:0]];
    end else if (blk >= `WLK_BLK_DYN_BASE) begin
      // Pair bits that point into the system area are dropped
      if (pair_idx < `WLK_DYN_IGN_LO || pair_idx > `WLK_DYN_IGN_HI) begin
        locked = dyn_bits[pair_idx];
      end
    end
  end
endmodule
`default_nettype wire

// ### wlk_nv_mem.v
// Non-volatile block store with registered read data and lock mirrors
`timescale 1ns/1ps
`default_nettype none
`include "wlk_regs.vh"
module wlk_nv_mem #(
  parameter DEPTH  = 64,
  parameter ADDR_W = 6,
  parameter DATA_W = 32
) (
  input  wire              clk,
  input  wire              wr_en,
  input  wire              rd_en,
  input  wire [ADDR_W-1:0] addr,
  input  wire [DATA_W-1:0] wr_data,
  input  wire              kill_set,
  output reg  [DATA_W-1:0] rd_data,
  output reg  [DATA_W-1:0] static_word,
  output reg  [DATA_W-1:0] lock_word,
  output reg  [DATA_W-1:0] pwd_word,
  output reg               kill_flag
);
  reg [DATA_W-1:0] cells [0:DEPTH-1];
  integer          i;

  // Factory content: all zero, password zero, not killed
  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      cells[i] = {DATA_W{1'b0}};
    end
    rd_data     = {DATA_W{1'b0}};
    static_word = {DATA_W{1'b0}};
    lock_word   = {DATA_W{1'b0}};
    pwd_word    = {DATA_W{1'b0}};
    kill_flag   = 1'b0;
  end

  // Whole-word commit in one edge, mirrors follow the same edge
  always @(posedge clk) begin
    if (wr_en) begin
      cells[addr] <= wr_data;
      if (addr == `WLK_BLK_STATIC) static_word <= wr_data;
      if (addr == `WLK_BLK_LOCKS) lock_word <= wr_data;
      if (addr == `WLK_BLK_PWD) pwd_word <= wr_data;
    end
    if (rd_en) rd_data <= cells[addr];
    if (kill_set) kill_flag <= 1'b1;
  end
endmodule
`default_nettype wire

// ### wlk_reader.sv
// Reader model issuing one block command at a time
`timescale 1ns/1ps
`default_nettype none
module wlk_reader (
  input  wire         mclk,
  input  wire         cmd_ready,
  input  wire         rsp_valid,
  input  wire  [3:0]  rsp_code,
  input  wire  [31:0] rsp_data,
  output logic        cmd_valid = 1'b0,
  output logic        cmd_write = 1'b0,
  output logic [5:0]  cmd_block = 6'h00,
  output logic [31:0] cmd_data = 32'h00000000
);
  // Offer after gap idle cycles, hold until taken, then await the answer
  task automatic xfer(input logic w, input logic [5:0] b, input logic [31:0] d,
                      input int gap, output logic got, output logic [3:0] code,
                      output logic [31:0] data);
    logic r;
    got = 1'b0;
    repeat (gap + 1) @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_block = b;
    cmd_data = d;
    do begin
      @(negedge mclk);
      r = cmd_ready;
      @(posedge mclk);
    end while (r !== 1'b1);
    #1;
    cmd_valid = 1'b0;
    cmd_block = ~b;
    cmd_data = ~d;
    for (int n = 0; n < 6 && !got; n++) begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        code = rsp_code;
        data = rsp_data;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### wlk_regs.vh
// Block addresses, field positions and answer codes of the write lock logic
`ifndef WLK_REGS_VH
`define WLK_REGS_VH
`define WLK_BLK_UID_LAST   6'h01
`define WLK_BLK_STATIC     6'h02
`define WLK_BLK_CC         6'h03
`define WLK_BLK_STAT_LAST  6'h0F
`define WLK_BLK_DYN_BASE   6'h10
`define WLK_BLK_LOCKS      6'h2C
`define WLK_BLK_PWD        6'h2F
`define WLK_BLK_KILL       6'h30
`define WLK_F_SLOW         23:16
`define WLK_F_SHIGH        31:24
`define WLK_F_DYN          23:0
`define WLK_F_SYS          28:24
`define WLK_SLOW_LSB       16
`define WLK_LD_CC          0
`define WLK_LD_MID         1
`define WLK_LD_TOP         2
`define WLK_FRZ_LOW_CC     8'h08
`define WLK_FRZ_LOW_MID    8'hF0
`define WLK_FRZ_HIGH_MID   8'h03
`define WLK_FRZ_HIGH_TOP   8'hFC
`define WLK_STATIC_WMASK   32'hFFFF0000
`define WLK_LOCKS_WMASK    32'h1FFFFFFF
`define WLK_DYN_IGN_LO     5'h0E
`define WLK_DYN_IGN_HI     5'h11
`define WLK_RSP_ACK        4'hA
`define WLK_RSP_NEGATIVE_ACK_CODE_ZERO      4'h0
`define WLK_WORD_ZERO      32'h00000000
`define WLK_HALF_ZERO      16'h0000
`endif

// ### wlk_write_lock_ctrl.v
// Write lock and kill control of a contactless tag memory
`timescale 1ns/1ps
`default_nettype none
`include "wlk_regs.vh"
// Operation
// - Static lock write changes writable bits, ACK
// - b0 set, b3 clear: capability container stays writable
// - b1 freezes low[7:4], high[1:0]
// - b2 freezes high[7:2]
// - Static bit b3 onward locks blocks 3..0Fh
// - Pair lock bits cover block pairs from 10h
// - Pair bits over system area are ignored
// - System bits b0..b4 lock blocks 2Ch..30h
// - Killed device ignores every command forever
// - Locked block 30h answers code-zero NACK
// - Matching password: ACK, set killed flag
// - Killed flag kills at each later power-up
// - Password writable until its system bit set
// - Reads of block 2Fh return zeros
// - Lock bits only set, never cleared, ACK unless system bit b0 locks 2Ch
// - Set lock bit makes region read-only
// - Lock updates never erase set bits
module wlk_write_lock_ctrl #(
  parameter ADDR_W = 6,
  parameter DATA_W = 32,
  parameter DEPTH  = 64
) (
  input  wire              MCLK,
  input  wire              SYS_RST,
  input  wire              CMD_VALID,
  output wire              CMD_READY,
  input  wire              CMD_WRITE,
  input  wire [ADDR_W-1:0] CMD_BLOCK,
  input  wire [DATA_W-1:0] CMD_DATA,
  output wire              RSP_VALID,
  output wire [3:0]        RSP_CODE,
  output wire [DATA_W-1:0] RSP_DATA,
  output wire              KILLED,
  output wire              KILL_PENDING
);
  // -----------------------------------------
  // States
  // -----------------------------------------
  localparam [4:0] ST_BOOT = 5'h01;
  localparam [4:0] ST_IDLE = 5'h02;
  localparam [4:0] ST_EXEC = 5'h04;
  localparam [4:0] ST_RDW  = 5'h08;
  localparam [4:0] ST_DEAD = 5'h10;

  reg  [4:0]        state_q;
  reg  [4:0]        state_d;
  reg               wr_q;
  reg  [ADDR_W-1:0] blk_q;
  reg  [DATA_W-1:0] data_q;
  reg               rsp_valid_q;
  reg  [3:0]        rsp_code_q;
  reg  [DATA_W-1:0] rsp_data_q;
  reg               killed_q;
  reg               pend_q;
  reg               wr_d;
  reg  [ADDR_W-1:0] blk_d;
  reg  [DATA_W-1:0] data_d;
  reg               rsp_valid_d;
  reg  [3:0]        rsp_code_d;
  reg  [DATA_W-1:0] rsp_data_d;
  reg               killed_d;
  reg               pend_d;

  // Decisions made in the execute cycle
  reg               mem_wr;
  reg               mem_rd;
  reg  [DATA_W-1:0] mem_wdata;
  reg               kill_hit;
  reg  [3:0]        code_d;
  reg  [7:0]        frz_low;
  reg  [7:0]        frz_high;
  reg  [DATA_W-1:0] frz_word;

  wire [DATA_W-1:0] rd_word;
  wire [DATA_W-1:0] static_word;
  wire [DATA_W-1:0] lock_word;
  wire [DATA_W-1:0] pwd_word;
  wire              kill_flag;
  wire              blk_locked;
  wire [ADDR_W-1:0] mem_addr;
  wire              take;

  // -----------------------------------------
  // Helpers
  // -----------------------------------------
  // True for the two blocks whose bits are one-time programmable
  function is_lock_block;
    input [ADDR_W-1:0] b;
    begin
      is_lock_block = (b == `WLK_BLK_STATIC) || (b == `WLK_BLK_LOCKS);
    end
  endfunction

  // Ones only add: a lock bit once set survives any write
  function [DATA_W-1:0] otp_merge;
    input [DATA_W-1:0] old;
    input [DATA_W-1:0] wr;
    input [DATA_W-1:0] allow;
    begin
      otp_merge = old | (wr & allow);
    end
  endfunction

  // -----------------------------------------
  // Storage and lock decoding
  // -----------------------------------------
  assign mem_addr = blk_q;

  wlk_nv_mem #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .clk         (MCLK),
    .wr_en       (mem_wr),
    .rd_en       (mem_rd),
    .addr        (mem_addr),
    .wr_data     (mem_wdata),
    .kill_set    (kill_hit),
    .rd_data     (rd_word),
    .static_word (static_word),
    .lock_word   (lock_word),
    .pwd_word    (pwd_word),
    .kill_flag   (kill_flag)
  );

  wlk_lock_map #(
    .ADDR_W (ADDR_W)
  ) u_map (
    .blk         (blk_q),
    .static_bits ({static_word[`WLK_F_SHIGH], static_word[`WLK_F_SLOW]}),
    .dyn_bits    (lock_word[`WLK_F_DYN]),
    .sys_bits    (lock_word[`WLK_F_SYS]),
    .locked      (blk_locked)
  );

  // -----------------------------------------
  // Static lock freeze masks
  // -----------------------------------------
  // A set disable bit pins its group at the current value
  always @* begin
    frz_low  = 8'h00;
    frz_high = 8'h00;
    if (static_word[`WLK_SLOW_LSB + `WLK_LD_CC]) begin
      frz_low = frz_low | `WLK_FRZ_LOW_CC;
    end
    if (static_word[`WLK_SLOW_LSB + `WLK_LD_MID]) begin
      frz_low  = frz_low | `WLK_FRZ_LOW_MID;
      frz_high = frz_high | `WLK_FRZ_HIGH_MID;
    end
    if (static_word[`WLK_SLOW_LSB + `WLK_LD_TOP]) begin
      frz_high = frz_high | `WLK_FRZ_HIGH_TOP;
    end
    frz_word = {frz_high, frz_low, `WLK_HALF_ZERO};
  end

  // -----------------------------------------
  // Execute decision
  // -----------------------------------------
  // Only the execute cycle touches the store; reads are masked later
  always @* begin
    mem_wr    = 1'b0;
    mem_rd    = 1'b0;
    mem_wdata = data_q;
    kill_hit  = 1'b0;
    code_d    = `WLK_RSP_ACK;
    if (state_q == ST_EXEC) begin
      if (!wr_q) begin
        mem_rd = 1'b1;
      end else if (blk_q == `WLK_BLK_KILL) begin
        if (blk_locked) begin
          code_d = `WLK_RSP_NEGATIVE_ACK_CODE_ZERO;
        end else if (data_q == pwd_word) begin
          kill_hit = 1'b1;
        end else begin
          code_d = `WLK_RSP_NEGATIVE_ACK_CODE_ZERO;
        end
      end else if (blk_q == `WLK_BLK_STATIC) begin
        mem_wr    = 1'b1;
        mem_wdata = otp_merge(static_word, data_q,
                              `WLK_STATIC_WMASK & ~frz_word);
      end else if (blk_locked) begin
        code_d = `WLK_RSP_NEGATIVE_ACK_CODE_ZERO;
      end else if (is_lock_block(blk_q)) begin
        mem_wr    = 1'b1;
        mem_wdata = otp_merge(lock_word, data_q, `WLK_LOCKS_WMASK);
      end else begin
        mem_wr = 1'b1;
      end
    end
  end

  // -----------------------------------------
  // Sequencer
  // -----------------------------------------
  assign take = CMD_VALID && CMD_READY;

  // Boot reads the killed flag once; a dead device never leaves its state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_BOOT: begin
        if (kill_flag) begin
          state_d = ST_DEAD;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (wr_q) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_RDW;
        end
      end
      ST_RDW: begin
        state_d = ST_IDLE;
      end
      ST_DEAD: begin
        state_d = ST_DEAD;
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  // State register
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  // Next command: latched only when the idle sequencer takes it
  always @* begin
    wr_d   = wr_q;
    blk_d  = blk_q;
    data_d = data_q;
    if (take && state_q == ST_IDLE) begin
      wr_d   = CMD_WRITE;
      blk_d  = CMD_BLOCK;
      data_d = CMD_DATA;
    end
  end

  // Command registers
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_q   <= 1'b0;
      blk_q  <= {ADDR_W{1'b0}};
      data_q <= `WLK_WORD_ZERO;
    end else begin
      wr_q   <= wr_d;
      blk_q  <= blk_d;
      data_q <= data_d;
    end
  end

  // -----------------------------------------
  // Answer path
  // -----------------------------------------
  // Next answer: one-cycle pulse; password block reads back as zeros
  always @* begin
    rsp_valid_d = 1'b0;
    rsp_code_d  = rsp_code_q;
    rsp_data_d  = rsp_data_q;
    if (state_q == ST_EXEC && wr_q) begin
      rsp_valid_d = 1'b1;
      rsp_code_d  = code_d;
      rsp_data_d  = `WLK_WORD_ZERO;
    end else if (state_q == ST_RDW) begin
      rsp_valid_d = 1'b1;
      rsp_code_d  = `WLK_RSP_ACK;
      if (blk_q == `WLK_BLK_PWD) begin
        rsp_data_d = `WLK_WORD_ZERO;
      end else begin
        rsp_data_d = rd_word;
      end
    end
  end

  // Answer registers; code and data hold until the next answer
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rsp_valid_q <= 1'b0;
      rsp_code_q  <= `WLK_RSP_ACK;
      rsp_data_q  <= `WLK_WORD_ZERO;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_code_q  <= rsp_code_d;
      rsp_data_q  <= rsp_data_d;
    end
  end

  // -----------------------------------------
  // Killed state
  // -----------------------------------------
  // Caught after reset release; a kill now only arms the next power-up
  always @* begin
    killed_d = killed_q;
    pend_d   = pend_q;
    if (state_q == ST_BOOT) begin
      killed_d = kill_flag;
      pend_d   = kill_flag;
    end
    if (kill_hit) begin
      pend_d = 1'b1;
    end
  end

  // Killed state registers
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      killed_q <= 1'b0;
      pend_q   <= 1'b0;
    end else begin
      killed_q <= killed_d;
      pend_q   <= pend_d;
    end
  end

  // -----------------------------------------
  // Outputs
  // -----------------------------------------
  // Dead device swallows commands without any answer
  assign CMD_READY    = (state_q == ST_IDLE) || (state_q == ST_DEAD);
  assign RSP_VALID    = rsp_valid_q;
  assign RSP_CODE     = rsp_code_q;
  assign RSP_DATA     = rsp_data_q;
  assign KILLED       = killed_q;
  assign KILL_PENDING = pend_q;
endmodule
`default_nettype wire

// ### wlk_write_lock_monitor.sv
// Port checker for the write lock and kill control
`timescale 1ns/1ps
`default_nettype none
`include "wlk_regs.vh"
module wlk_write_lock_monitor #(
  parameter ADDR_W = 6,
  parameter DATA_W = 32
) (
  input wire              MCLK,
  input wire              SYS_RST,
  input wire              CMD_VALID,
  input wire              CMD_READY,
  input wire              CMD_WRITE,
  input wire [ADDR_W-1:0] CMD_BLOCK,
  input wire [DATA_W-1:0] CMD_DATA,
  input wire              RSP_VALID,
  input wire [3:0]        RSP_CODE,
  input wire [DATA_W-1:0] RSP_DATA,
  input wire              KILLED,
  input wire              KILL_PENDING
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  // Commands taken while the device is alive
  wire wr_go = CMD_VALID && CMD_READY && CMD_WRITE && !KILLED;
  wire rd_go = CMD_VALID && CMD_READY && !CMD_WRITE && !KILLED;
  property p_wr_time;
    wr_go |-> ##1 !CMD_READY ##1 RSP_VALID;
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("write answer off time");
  property p_static_ack;
    wr_go && CMD_BLOCK == `WLK_BLK_STATIC |-> ##2 RSP_CODE == `WLK_RSP_ACK;
  endproperty
  a_static_ack: assert property (p_static_ack) else $error("static lock write refused");
  property p_pwd_hidden;
    rd_go && CMD_BLOCK == `WLK_BLK_PWD |-> ##3 RSP_VALID && RSP_DATA == `WLK_WORD_ZERO;
  endproperty
  a_pwd_hidden: assert property (p_pwd_hidden) else $error("password visible");
  property p_id_nack;
    wr_go && CMD_BLOCK <= `WLK_BLK_UID_LAST |-> ##2 RSP_VALID && RSP_CODE == `WLK_RSP_NEGATIVE_ACK_CODE_ZERO;
  endproperty
  a_id_nack: assert property (p_id_nack) else $error("identity block written");
  property p_mute;
    KILLED |=> KILLED && !RSP_VALID;
  endproperty
  a_mute: assert property (p_mute) else $error("killed device answered");
  property p_kill_set;
    wr_go && CMD_BLOCK == `WLK_BLK_KILL ##2 RSP_CODE == `WLK_RSP_ACK |=> KILL_PENDING;
  endproperty
  a_kill_set: assert property (p_kill_set) else $error("kill flag not set");
  property p_no_early;
    !KILLED && !$fell(SYS_RST) |=> !KILLED;
  endproperty
  a_no_early: assert property (p_no_early) else $error("killed outside power-up");
  property p_boot;
    $fell(SYS_RST) |=> KILLED == KILL_PENDING && CMD_READY;
  endproperty
  a_boot: assert property (p_boot) else $error("boot state wrong");
endmodule
bind wlk_write_lock_ctrl wlk_write_lock_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_mon (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .CMD_WRITE(CMD_WRITE), .CMD_BLOCK(CMD_BLOCK), .CMD_DATA(CMD_DATA), .RSP_VALID(RSP_VALID),
  .RSP_CODE(RSP_CODE), .RSP_DATA(RSP_DATA), .KILLED(KILLED), .KILL_PENDING(KILL_PENDING));
`default_nettype wire
